// file: qwd_pkg.sv
// shared constants for the quad wiper serial command decoder
package qwd_pkg;
  localparam int        NUM_POTS      = 4;
  localparam int        NUM_SLOTS     = 4;
  localparam int        WIPER_W       = 6;
  localparam logic [5:0] WIPER_MAX    = 6'h3f;
  localparam logic [5:0] WIPER_MIN    = 6'h00;
  localparam logic [5:0] SLOT_RST     = 6'h00;
  localparam logic [5:0] WIPER_RST    = 6'h00;
  // arbitrary device type nibble, not a real code
  localparam logic [3:0] DEV_TYPE_DEF = 4'h3;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam int        CLK_HZ        = 10_000_000;
  localparam int        NV_WRITE_MS   = 5;
  localparam int        NV_WRITE_CYC  = (CLK_HZ / 1000) * NV_WRITE_MS;
  localparam logic [3:0] OP_RD_WIPER  = 4'h9;
  localparam logic [3:0] OP_WR_WIPER  = 4'ha;
  localparam logic [3:0] OP_RD_SLOT   = 4'hb;
  localparam logic [3:0] OP_WR_SLOT   = 4'hc;
  localparam logic [3:0] OP_CP_S2W    = 4'hd;
  localparam logic [3:0] OP_CP_W2S    = 4'he;
  localparam logic [3:0] OP_GCP_S2W   = 4'h1;
  localparam logic [3:0] OP_GCP_W2S   = 4'h8;
  localparam logic [3:0] OP_STEP      = 4'h2;
  typedef enum logic [9:0] {
    QWD_IDLE  = 10'b00_0000_0001,
    QWD_ADDR  = 10'b00_0000_0010,
    QWD_ACK_A = 10'b00_0000_0100,
    QWD_INSTR = 10'b00_0000_1000,
    QWD_ACK_I = 10'b00_0001_0000,
    QWD_WDATA = 10'b00_0010_0000,
    QWD_ACK_W = 10'b00_0100_0000,
    QWD_RDATA = 10'b00_1000_0000,
    QWD_ACK_R = 10'b01_0000_0000,
    QWD_STEP  = 10'b10_0000_0000
  } qwd_state_t;
endpackage

// file: qwd_line_if.sv
// synchronised serial line events between the front end and the decoder
`timescale 1ns/1ps
interface qwd_line_if;
  logic       scl_rise;
  logic       scl_fall;
  logic       sda;
  logic       start;
  logic       stop;
  logic [3:0] strap;
  modport front (output scl_rise, output scl_fall, output sda, output start, output stop,
                 output strap);
  modport core (input scl_rise, input scl_fall, input sda, input start, input stop,
                input strap);
endinterface

// file: qwd_line_sync.sv
// three-flop synchronisers on clock and data, two-flop on the strap, and edge, start and stop detection
`timescale 1ns/1ps
module qwd_line_sync (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [3:0] strap_i,
  qwd_line_if.front       line
);
  logic [1:0] scl_m_q;
  logic [1:0] sda_m_q;
  logic [3:0] strap_m_q;
  logic [3:0] strap_s_q;
  logic       scl_s_q;
  logic       sda_s_q;
  logic       scl_p_q;
  logic       sda_p_q;

  // idle bus is high, so reset to high avoids a false start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_m_q <= 2'h3;
      sda_m_q <= 2'h3;
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= {scl_m_q[0], scl_i};
      sda_m_q <= {sda_m_q[0], sda_i};
      scl_s_q <= scl_m_q[1];
      sda_s_q <= sda_m_q[1];
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_m_q <= 4'h0;
      strap_s_q <= 4'h0;
    end else begin
      strap_m_q <= strap_i;
      strap_s_q <= strap_m_q;
    end
  end

  assign line.scl_rise = scl_s_q & ~scl_p_q;
  assign line.scl_fall = ~scl_s_q & scl_p_q;
  assign line.sda      = sda_s_q;
  assign line.start    = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign line.stop     = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign line.strap    = strap_s_q;
endmodule // qwd_line_sync

// file: qwd_top.sv
// quad wiper serial command decoder with non-volatile setting slots
`timescale 1ns/1ps
module qwd_top
  import qwd_pkg::*;
#(
  parameter int         NV_CYCLES = NV_WRITE_CYC,
  parameter logic [3:0] DEV_TYPE  = DEV_TYPE_DEF
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          scl_i,
  input  wire logic                          sda_i,
  input  wire logic [3:0]                    strap_addr_i,
  output logic                               sda_o,
  output logic                               sda_oe_o,
  output logic                               busy_o,
  output logic [NUM_POTS*WIPER_W-1:0]        wiper_pos_o
);
  localparam int CNT_W = $clog2(NV_CYCLES + 1);

  qwd_line_if line ();

  qwd_line_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .strap_i (strap_addr_i),
    .line    (line)
  );

  qwd_state_t        state_q;
  logic [3:0]        cnt_q;
  logic [7:0]        shift_q;
  logic [7:0]        tx_q;
  logic              oe_q;
  logic              init_q;
  logic              busy_q;
  logic [CNT_W-1:0]  busy_cnt_q;
  logic              pend_q;
  logic [3:0]        op_q;
  logic [1:0]        pot_q;
  logic [1:0]        slot_q;
  logic [5:0]        data_q;
  logic [5:0]        wiper_q [NUM_POTS];
  logic [5:0]        nv_q    [NUM_POTS][NUM_SLOTS];

  logic byte_end;
  logic addr_ok;
  logic op_ok;
  logic exec;
  logic nv_op;

  assign byte_end = line.scl_fall && (cnt_q == BYTE_BITS);
  // a busy device refuses its address so the host can poll
  assign addr_ok  = (shift_q == {DEV_TYPE, line.strap}) && !busy_q;
  assign op_ok    = (shift_q[7:4] == OP_RD_WIPER) || (shift_q[7:4] == OP_WR_WIPER) ||
                    (shift_q[7:4] == OP_RD_SLOT)  || (shift_q[7:4] == OP_WR_SLOT)  ||
                    (shift_q[7:4] == OP_CP_S2W)   || (shift_q[7:4] == OP_CP_W2S)   ||
                    (shift_q[7:4] == OP_STEP)     ||
                    ((shift_q[7:4] == OP_GCP_S2W) && (shift_q[3:2] == 2'h0)) ||
                    ((shift_q[7:4] == OP_GCP_W2S) && (shift_q[3:2] == 2'h0));
  assign exec     = line.stop && pend_q;
  assign nv_op    = (op_q == OP_WR_SLOT) || (op_q == OP_CP_W2S) || (op_q == OP_GCP_W2S);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= QWD_IDLE;
    end else if (line.start) begin
      state_q <= QWD_ADDR;
    end else if (line.stop) begin
      state_q <= QWD_IDLE;
    end else begin
      case (state_q)
        QWD_ADDR: begin
          if (byte_end) state_q <= addr_ok ? QWD_ACK_A : QWD_IDLE;
        end
        QWD_ACK_A: begin
          if (line.scl_fall) state_q <= QWD_INSTR;
        end
        QWD_INSTR: begin
          if (byte_end) state_q <= op_ok ? QWD_ACK_I : QWD_IDLE;
        end
        QWD_ACK_I: begin
          if (line.scl_fall) begin
            case (op_q)
              OP_RD_WIPER, OP_RD_SLOT: state_q <= QWD_RDATA;
              OP_WR_WIPER, OP_WR_SLOT: state_q <= QWD_WDATA;
              OP_STEP:                 state_q <= QWD_STEP;
              default:                 state_q <= QWD_IDLE;
            endcase
          end
        end
        QWD_WDATA: begin
          if (byte_end) state_q <= QWD_ACK_W;
        end
        QWD_ACK_W: begin
          if (line.scl_fall) state_q <= QWD_IDLE;
        end
        QWD_RDATA: begin
          if (byte_end) state_q <= QWD_ACK_R;
        end
        QWD_ACK_R: begin
          if (line.scl_fall) state_q <= QWD_IDLE;
        end
        QWD_STEP:  state_q <= QWD_STEP;
        default:   state_q <= QWD_IDLE;
      endcase
    end
  end

  // bit counter and receive shifter
  always_ff @(posedge clk_i) begin
    if (rst_i || line.start) begin
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
    end else if (line.scl_fall && (cnt_q == BYTE_BITS)) begin
      cnt_q   <= 4'h0;
    end else if (line.scl_rise && (state_q == QWD_ADDR || state_q == QWD_INSTR ||
                                   state_q == QWD_WDATA || state_q == QWD_RDATA ||
                                   state_q == QWD_STEP)) begin
      cnt_q   <= cnt_q + 4'h1;
      shift_q <= {shift_q[6:0], line.sda};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || line.start || line.stop) begin
      oe_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (line.scl_fall) begin
      case (state_q)
        QWD_ADDR:  oe_q <= byte_end && addr_ok;
        QWD_INSTR: oe_q <= byte_end && op_ok;
        QWD_WDATA: oe_q <= byte_end;
        QWD_ACK_I: begin
          if (op_q == OP_RD_WIPER) begin
            oe_q <= ~1'b0;
            tx_q <= {2'h0, wiper_q[pot_q]};
          end else if (op_q == OP_RD_SLOT) begin
            oe_q <= ~1'b0;
            tx_q <= {2'h0, nv_q[pot_q][slot_q]};
          end else begin
            oe_q <= 1'b0;
          end
        end
        QWD_RDATA: begin
          if (byte_end) begin
            oe_q <= 1'b0;
          end else begin
            oe_q <= ~tx_q[6];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        default:   oe_q <= 1'b0;
      endcase
    end
  end

  // latch instruction and data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_q   <= 4'h0;
      pot_q  <= 2'h0;
      slot_q <= 2'h0;
      data_q <= 6'h00;
    end else if (byte_end && state_q == QWD_INSTR) begin
      op_q   <= shift_q[7:4];
      pot_q  <= shift_q[3:2];
      slot_q <= shift_q[1:0];
    end else if (byte_end && state_q == QWD_WDATA) begin
      data_q <= shift_q[5:0];
    end
  end

  // pending work armed by complete bytes
  always_ff @(posedge clk_i) begin
    if (rst_i || line.start || line.stop) begin
      pend_q <= 1'b0;
    end else if (line.scl_fall && state_q == QWD_ACK_W) begin
      pend_q <= 1'b1;
    end else if (line.scl_fall && state_q == QWD_ACK_I) begin
      pend_q <= (op_q == OP_CP_S2W) || (op_q == OP_CP_W2S) ||
                (op_q == OP_GCP_S2W) || (op_q == OP_GCP_W2S);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q     <= 1'b0;
      busy_cnt_q <= '0;
    end else if (exec && nv_op) begin
      busy_q     <= 1'b1;
      busy_cnt_q <= CNT_W'(NV_CYCLES - 1);
    end else if (busy_q) begin
      busy_cnt_q <= busy_cnt_q - CNT_W'(1);
      if (busy_cnt_q == '0) busy_q <= 1'b0;
    end
  end

  // power-up recall happens the cycle after reset
  always_ff @(posedge clk_i) begin
    init_q <= rst_i;
  end

  for (genvar g = 0; g < NUM_POTS; g++) begin : g_pot
    logic sel;
    assign sel = (pot_q == 2'(g));

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        wiper_q[g] <= WIPER_RST;
      end else if (init_q) begin
        wiper_q[g] <= nv_q[g][0];
      end else if (exec && sel && op_q == OP_WR_WIPER) begin
        wiper_q[g] <= data_q;
      end else if (exec && op_q == OP_GCP_S2W) begin
        wiper_q[g] <= nv_q[g][slot_q];
      end else if (exec && sel && op_q == OP_CP_S2W) begin
        wiper_q[g] <= nv_q[g][slot_q];
      end else if (state_q == QWD_STEP && sel && line.scl_fall) begin
        // step on fall, direction from rise; stop pulse never falls
        if (shift_q[0] && wiper_q[g] != WIPER_MAX) begin
          wiper_q[g] <= wiper_q[g] + 6'h01;
        end else if (!shift_q[0] && wiper_q[g] != WIPER_MIN) begin
          wiper_q[g] <= wiper_q[g] - 6'h01;
        end
      end
    end

    // slots are reset only because simulation has no stored contents
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        for (int s = 0; s < NUM_SLOTS; s++) begin
          nv_q[g][s] <= SLOT_RST;
        end
      end else if (exec && sel && op_q == OP_WR_SLOT) begin
        nv_q[g][slot_q] <= data_q;
      end else if (exec && op_q == OP_GCP_W2S) begin
        nv_q[g][slot_q] <= wiper_q[g];
      end else if (exec && sel && op_q == OP_CP_W2S) begin
        nv_q[g][slot_q] <= wiper_q[g];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        wiper_pos_o[g*WIPER_W +: WIPER_W] <= WIPER_RST;
      end else begin
        wiper_pos_o[g*WIPER_W +: WIPER_W] <= wiper_q[g];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
      busy_o   <= 1'b0;
    end else begin
      sda_o    <= 1'b0;
      sda_oe_o <= oe_q;
      busy_o   <= busy_q;
    end
  end
endmodule // qwd_top

// file: qwd_top_assertions.sv
// port checks for the quad wiper decoder
`timescale 1ns/1ps
module qwd_top_assertions
  import qwd_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYC
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic [3:0]  strap_addr_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic        busy_o,
  input wire logic [23:0] wiper_pos_o
);
  logic [15:0] busy_n_q;
  logic [3:0]  stop_ago_q;
  logic [3:0]  edge_ago_q;
  logic        sda_p_q;
  logic        scl_p_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    busy_n_q <= busy_o ? busy_n_q + 16'h0001 : 16'h0000;
  end
  // saturating ages of the last pin stop and clock edge
  always_ff @(posedge clk_i) begin
    sda_p_q    <= sda_i;
    scl_p_q    <= scl_i;
    stop_ago_q <= (rst_i || (scl_i && sda_i && !sda_p_q)) ? 4'h0 :
                  stop_ago_q + {3'h0, stop_ago_q != 4'hf};
    edge_ago_q <= (rst_i || (scl_i != scl_p_q)) ? 4'h0 :
                  edge_ago_q + {3'h0, edge_ago_q != 4'hf};
  end
  a_sda_low_only: assert property (sda_o == 1'b0)
    else $error("data pin not driven low");
  a_reset_clear: assert property ($fell(rst_i) |-> !sda_oe_o && !busy_o &&
                                  wiper_pos_o == 24'h0)
    else $error("outputs not clear after reset");
  a_busy_length: assert property ($fell(busy_o) |-> busy_n_q == 16'(NV_CYCLES))
    else $error("busy length wrong");
  a_prog_after_stop: assert property ($rose(busy_o) |-> stop_ago_q <= 4'h8)
    else $error("programming began without stop");
  a_busy_no_ack: assert property (busy_o |-> !sda_oe_o)
    else $error("busy device acknowledged");
  a_wiper_cause: assert property (!$stable(wiper_pos_o) |->
                                  stop_ago_q <= 4'h8 || edge_ago_q <= 4'h8)
    else $error("wiper moved without cause");
  a_ack_in_low: assert property ($rose(sda_oe_o) |-> !scl_i [*3])
    else $error("drive began with clock high");
  a_oe_hold_high: assert property ($rose(scl_i) |=> $stable(sda_oe_o) [*6])
    else $error("data moved while clock high");
endmodule // qwd_top_assertions

// file: qwd_host_model.sv
// bus host model: drives the serial clock and open drain data
`timescale 1ns/1ps
module qwd_host_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // data moves only with clock low
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o = ~b;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    r = sda_i;
    tick(4);
    scl_o = 1'b0;
    tick(4);
  endtask
  task automatic start();
    sda_oe_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_oe_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
    tick(4);
  endtask
  // clock stands high, line released, after stop
  task automatic stop();
    sda_oe_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    sda_oe_o = 1'b0;
    tick(8);
  endtask
  // msb first, ack slot after byte
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule // qwd_host_model

// file: quad_wiper_i2c_command_decoder_tb.sv
// self-checking bench for the quad wiper serial command decoder
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module quad_wiper_i2c_command_decoder_tb;
  import qwd_pkg::*;
  // short programming time keeps the run brief
  localparam int NV = 400;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  strap = 4'h0;
  logic [3:0]  flip = 4'h0;
  wire logic   scl, h_oe, sda_o, sda_oe_o, busy_o;
  wire logic   sda = !(h_oe || sda_oe_o);
  wire logic [23:0] wp_o;
  int          n_errors = 0, checks = 0, cyc = 0, seed = 32'h8c4b, p, q;
  logic [5:0]  wp [4];
  logic [5:0]  sl [4][4];
  logic [7:0]  r, d, pat;
  logic [1:0]  s;
  always #50 clk_i = ~clk_i;
  qwd_host_model host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
  qwd_top #(.NV_CYCLES(NV)) dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .strap_addr_i(strap), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o), .wiper_pos_o(wp_o));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      end_sim();
    end
  end
  function automatic logic [5:0] stp(input logic [5:0] w, input logic up);
    if (up) return (w == WIPER_MAX) ? w : w + 6'h1;
    return (w == WIPER_MIN) ? w : w - 6'h1;
  endfunction
  function automatic logic [23:0] all_wp();
    return {wp[3], wp[2], wp[1], wp[0]};
  endfunction
  // k: 0 two-byte, 1 write, 2 read, 3 step left open, 4 refused op
  task automatic xfer(input logic [7:0] ins, input int k, input logic [7:0] dv, input logic ea);
    logic a;
    host.start();
    host.wbyte({DEV_TYPE_DEF, strap ^ flip}, a);
    `CHK(a, ea)
    if (a === 1'b1) begin
      host.wbyte(ins, a);
      `CHK(a, k != 4)
      if (k == 1) host.wbyte(dv, a);
      if (k == 1) `CHK(a, 1'b1)
      if (k == 2) host.rbyte(r, 1'b1);
    end
    if (k != 3) host.stop();
  endtask
  task automatic nvwait();
    for (int i = 0; i < 1000 && busy_o !== 1'b0; i++) host.tick(1);
  endtask
  initial begin
    for (p = 0; p < 16; p++) sl[p/4][p%4] = SLOT_RST;
    strap = 4'($random(seed));
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    host.tick(8);
    for (p = 0; p < 4; p++) wp[p] = sl[p][0];
    `CHK(wp_o, all_wp())
    for (p = 0; p < 4; p++) begin
      d = 8'($random(seed));
      wp[p] = d[5:0];
      xfer({OP_WR_WIPER, 2'(p), 2'h0}, 1, d, 1'b1);
      `CHK(wp_o, all_wp())
      xfer({OP_RD_WIPER, 2'(p), 2'h0}, 2, 8'h00, 1'b1);
      `CHK(r, {2'h0, wp[p]})
    end
    flip = 4'h4;
    xfer({OP_WR_WIPER, 2'h0, 2'h0}, 1, 8'h2a, 1'b0);
    flip = 4'h0;
    `CHK(wp_o, all_wp())
    `CHK(sda_o, 1'b0)
    $display("wiper test done");
    for (p = 0; p < 4; p++) begin
      s = 2'($random(seed));
      d = 8'($random(seed));
      xfer({OP_WR_SLOT, 2'(p), s}, 1, d, 1'b1);
      sl[p][s] = d[5:0];
      `CHK(busy_o, 1'b1)
      xfer(8'h00, 0, 8'h00, 1'b0);
      nvwait();
      xfer({OP_RD_SLOT, 2'(p), s}, 2, 8'h00, 1'b1);
      `CHK(r, {2'h0, sl[p][s]})
      xfer({OP_CP_S2W, 2'(p), s}, 0, 8'h00, 1'b1);
      wp[p] = sl[p][s];
      `CHK(wp_o, all_wp())
    end
    xfer({OP_CP_W2S, 2'h1, 2'h3}, 0, 8'h00, 1'b1);
    sl[1][3] = wp[1];
    nvwait();
    xfer({OP_RD_SLOT, 2'h1, 2'h3}, 2, 8'h00, 1'b1);
    `CHK(r, {2'h0, sl[1][3]})
    xfer({OP_GCP_W2S, 2'h0, 2'h2}, 0, 8'h00, 1'b1);
    nvwait();
    for (p = 0; p < 4; p++) begin
      sl[p][2] = wp[p];
      xfer({OP_RD_SLOT, 2'(p), 2'h2}, 2, 8'h00, 1'b1);
      `CHK(r, {2'h0, sl[p][2]})
    end
    xfer({OP_GCP_S2W, 2'h0, 2'h1}, 0, 8'h00, 1'b1);
    for (p = 0; p < 4; p++) wp[p] = sl[p][1];
    `CHK(wp_o, all_wp())
    // global copy with pot bits set is refused and moves nothing
    xfer({OP_GCP_S2W, 2'h1, 2'h0}, 4, 8'h00, 1'b1);
    `CHK(wp_o, all_wp())
    $display("slot test done");
    // both ends first, then random directions
    for (p = 0; p < 3; p++) begin
      wp[2] = (p == 0) ? 6'h3e : (p == 1) ? 6'h01 : 6'($random(seed));
      pat = (p == 0) ? 8'h07 : (p == 1) ? 8'hf8 : 8'($random(seed));
      xfer({OP_WR_WIPER, 2'h2, 2'h0}, 1, {2'h0, wp[2]}, 1'b1);
      xfer({OP_STEP, 2'h2, 2'h0}, 3, 8'h00, 1'b1);
      for (q = 0; q < 8; q++) begin
        host.bit_io(pat[q], d[0]);
        // wiper moves a few cycles after the clock falls
        host.tick(2);
        wp[2] = stp(wp[2], pat[q]);
        `CHK(wp_o, all_wp())
      end
      host.stop();
      `CHK(wp_o, all_wp())
    end
    $display("step test done");
    end_sim();
  end
endmodule // quad_wiper_i2c_command_decoder_tb
bind qwd_top qwd_top_assertions #(.NV_CYCLES(NV_CYCLES)) chk (.clk_i(clk_i), .rst_i(rst_i),
  .scl_i(scl_i), .sda_i(sda_i), .strap_addr_i(strap_addr_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .busy_o(busy_o), .wiper_pos_o(wiper_pos_o));
